/* File: hdl/ism_channel.sv */
// one indicator instance: decode two status inputs, detect changes
// assumes inputs are already synchronised to clk_sys
module ism_channel
  import ism_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // status inputs
  input  wire logic       open_in,
  input  wire logic       close_in,
  // decoded state and change flags
  output ism_state_t      state,
  output logic [3:0]      rise,
  output logic [3:0]      fall
);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  ism_state_t nxt_state;
  logic [3:0] state_ff;

  always_comb begin
    case ({open_in, close_in})
      2'b10:   nxt_state = ISM_ST_OPEN;
      2'b01:   nxt_state = ISM_ST_CLOSED;
      2'b11:   nxt_state = ISM_ST_BAD;
      default: nxt_state = ISM_ST_INTER;
    endcase
  end

  // ----------------------------------------
  // change detection
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign state = ism_state_t'(state_ff);
  assign rise  = nxt_state & ~state_ff;
  assign fall  = ~nxt_state & state_ff;

endmodule

/* File: hdl/ism_pkg.sv */
// package for the indicator status monitor: states, events, timing
// assumes a single 50 MHz system clock
package ism_pkg;

  // ----------------------------------------
  // sizes and timing
  // ----------------------------------------
  localparam int unsigned NUM_IND       = 10;
  localparam int unsigned IND_IDX_W     = 4;
  localparam int unsigned STAMP_W       = 32;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned STAMP_RES_US  = 1000;
  localparam int unsigned STAMP_DIV     = (CLK_HZ / 1_000_000) * STAMP_RES_US;
  localparam int unsigned STAMP_DIV_W   = 16;
  localparam logic [STAMP_W-1:0] STAMP_RST = 32'h0000_0000;

  // ----------------------------------------
  // decoded states, one-hot: bit order open, closed, intermediate, bad
  // ----------------------------------------
  typedef enum logic [3:0] {
    ISM_ST_OPEN   = 4'h1,
    ISM_ST_CLOSED = 4'h2,
    ISM_ST_INTER  = 4'h4,
    ISM_ST_BAD    = 4'h8
  } ism_state_t;
  localparam logic [3:0] ST_RST = 4'h4;

  // ----------------------------------------
  // event store selection
  // ----------------------------------------
  typedef enum logic [1:0] {
    ISM_SEL_NONE = 2'h0,
    ISM_SEL_ON   = 2'h1,
    ISM_SEL_OFF  = 2'h2,
    ISM_SEL_BOTH = 2'h3
  } ism_sel_t;

  typedef struct packed {
    logic [IND_IDX_W-1:0] instance_no;
    logic [1:0]           event_code;
    logic                 is_on;
    logic [STAMP_W-1:0]   stamp;
  } ism_event_t;

endpackage

/* File: hdl/ism_top.sv */
// indicator status monitor: ten instances feeding one event port
// assumes status inputs are asynchronous pins or user logic signals
// assumes selections are held steady while monitoring
//
// Overview of operation
// - with neither open nor close input active the state is intermediate.
// - with both open and close inputs active the state is bad.
// - a one on the open input means the monitored device is open.
// - a one on the close input means the monitored device is closed.
// - each indicator reads two separate status inputs, one for open and one for closed.
// - a change of any of the four state signals raises separate time-stamped on and off events.
// - time stamps count whole milliseconds.
// - a per-event selection stores on only, off only, or both.
// - ten independent instances, numbered one to ten, each with own inputs and events.
// - the block only reports and drives no switching command.
module ism_top
  import ism_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  // status inputs, one pair per instance
  input  wire logic [NUM_IND-1:0]     open_status_in,
  input  wire logic [NUM_IND-1:0]     close_status_in,
  // per-instance, per-event store selection
  input  wire logic [NUM_IND*8-1:0]   event_sel,
  // decoded states
  output logic [NUM_IND*4-1:0]        ind_state,
  // event output towards the shared buffer
  output logic                        evt_valid,
  output ism_event_t                  evt_data,
  output logic                        evt_lost,
  // millisecond time base
  output logic [STAMP_W-1:0]          stamp
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [NUM_IND-1:0] open_meta_ff;
  logic [NUM_IND-1:0] open_sync_ff;
  logic [NUM_IND-1:0] close_meta_ff;
  logic [NUM_IND-1:0] close_sync_ff;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      open_meta_ff  <= '0;
      open_sync_ff  <= '0;
      close_meta_ff <= '0;
      close_sync_ff <= '0;
    end else begin
      open_meta_ff  <= open_status_in;
      open_sync_ff  <= open_meta_ff;
      close_meta_ff <= close_status_in;
      close_sync_ff <= close_meta_ff;
    end
  end

  // ----------------------------------------
  // millisecond time stamp
  // ----------------------------------------
  logic [STAMP_DIV_W-1:0] div_ff;
  logic [STAMP_W-1:0]     stamp_ff;
  logic                   ms_tick;

  assign ms_tick = (div_ff == STAMP_DIV_W'(STAMP_DIV - 1));

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_ff <= '0;
    end else if (ms_tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stamp_ff <= STAMP_RST;
    end else if (ms_tick) begin
      stamp_ff <= stamp_ff + 1'b1;
    end
  end

  assign stamp = stamp_ff;

  // ----------------------------------------
  // instances and event request flags
  // ----------------------------------------
  // pending bits: [inst*8 + ev*2 + 0] on, [+1] off
  logic [NUM_IND*8-1:0] req_on;
  logic [NUM_IND*8-1:0] pend_ff;
  logic [NUM_IND*8-1:0] grant;
  logic                 lost_pulse;

  genvar gi, ge;
  generate
    for (gi = 0; gi < NUM_IND; gi++) begin : g_ind
      ism_state_t st;
      logic [3:0] rs;
      logic [3:0] fl;
      ism_channel u_chan (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .open_in  (open_sync_ff[gi]),
        .close_in (close_sync_ff[gi]),
        .state    (st),
        .rise     (rs),
        .fall     (fl)
      );
      assign ind_state[gi*4 +: 4] = st;
      for (ge = 0; ge < 4; ge++) begin : g_ev
        // selection bit 0 stores on, bit 1 stores off
        assign req_on[gi*8+ge*2]   = rs[ge] & event_sel[gi*8+ge*2];
        assign req_on[gi*8+ge*2+1] = fl[ge] & event_sel[gi*8+ge*2+1];
      end
    end
  endgenerate

  // ----------------------------------------
  // arbitration: lowest index first, one event per cycle
  // ----------------------------------------
  logic [NUM_IND*8-1:0] pend_all;
  assign pend_all = pend_ff | req_on;
  assign grant    = pend_all & (~pend_all + 1'b1);
  // a repeat request on a still-pending slot folds into it
  // a granted slot still loses the repeat: only one event leaves for two requests
  assign lost_pulse = |(req_on & pend_ff);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= pend_all & ~grant;
    end
  end

  // ----------------------------------------
  // event output register
  // ----------------------------------------
  logic [6:0] gidx;
  always_comb begin
    gidx = '0;
    for (int k = 0; k < NUM_IND*8; k++) begin
      if (grant[k]) begin
        gidx = 7'(k);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      evt_valid <= 1'b0;
      evt_data  <= '0;
      evt_lost  <= 1'b0;
    end else begin
      evt_valid            <= |grant;
      evt_lost             <= lost_pulse;
      evt_data.instance_no <= IND_IDX_W'(gidx[6:3] + 4'h1);
      evt_data.event_code  <= gidx[2:1];
      evt_data.is_on       <= ~gidx[0];
      evt_data.stamp       <= stamp_ff;
    end
  end

  // no command outputs exist on this block

endmodule

/* File: test/indicator_status_monitor_test.sv */
// testbench: decode of every input pair, event order and store selection
// assumes the run reaches the first stamp tick, about 50000 cycles after reset
module indicator_status_monitor_test import ism_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_sys = 0;
  logic                 rst_b = 0;
  logic [NUM_IND-1:0]   open_in = '0;
  logic [NUM_IND-1:0]   close_in = '0;
  logic [NUM_IND*8-1:0] sel = '0;
  logic [NUM_IND*4-1:0] ind_state;
  logic                 evt_valid;
  logic                 evt_lost;
  ism_event_t           evt_data;
  logic [STAMP_W-1:0]   stamp;
  int                   n_fail = 0;
  int                   cmp_count = 0;
  int                   cyc = 0;
  always #10 clk_sys = ~clk_sys;
  ism_top i_dut (.clk_sys, .rst_b, .open_status_in(open_in), .close_status_in(close_in),
    .event_sel(sel), .ind_state, .evt_valid, .evt_data, .evt_lost, .stamp);
  ism_sink i_sink (.clk_sys, .evt_valid, .evt_data);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string what, logic [39:0] exp, logic [39:0] got);
    cmp_count++;
    if (exp !== got) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // ce is code and on flag; an empty log reads as all ones
  task automatic ev_at(logic [3:0] inst, logic [2:0] ce);
    logic [6:0] got;
    got = (i_sink.got_q.size() > 0) ? i_sink.got_q.pop_front() : 7'h7f;
    chk("event", {inst, ce}, got);
  endtask
  task automatic ev(logic [2:0] ce);
    ev_at(4'h1, ce);
  endtask
  task automatic t_single(logic x);
    open_in[0] = x;
    close_in[0] = ~x;
    step(8);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_decode();
    logic [3:0] lut [4] = '{4'h4, 4'h2, 4'h1, 4'h8};
    for (int s = 0; s < 4; s++) begin
      for (int i = 0; i < NUM_IND; i++) begin
        {open_in[i], close_in[i]} = 2'((s + i) % 4);
      end
      step(6);
      for (int i = 0; i < NUM_IND; i++) begin
        chk("ind_state", lut[(s + i) % 4], ind_state[i*4+:4]);
      end
    end
  endtask
  task automatic t_events();
    open_in = '0;
    close_in = '0;
    step(6);
    sel[7:0] = 8'hff;
    i_sink.got_q.delete();
    open_in[0] = 1;
    step(8);
    ev(3'b001);
    ev(3'b100);
    close_in[0] = 1;
    step(8);
    ev(3'b000);
    ev(3'b111);
    chk("stamp", 0, stamp);
  endtask
  task automatic t_select();
    sel[7:0] = 8'h55;
    t_single(1);
    ev(3'b001);
    t_single(0);
    ev(3'b011);
    sel[7:0] = 8'haa;
    t_single(1);
    ev(3'b010);
    chk("log size", 0, i_sink.got_q.size());
  endtask
  // nine instances change at once; instance ten bounces while its slots still wait
  task automatic t_burst();
    int lost;
    lost = 0;
    sel = '1;
    i_sink.got_q.delete();
    open_in[9:1] = '1;
    step(4);
    open_in[9] = 1'b0;
    step(2);
    open_in[9] = 1'b1;
    for (int k = 0; k < 24; k++) begin
      step(1);
      if (evt_lost === 1'b1) begin
        lost++;
      end
    end
    chk("lost pulses", 1, lost);
    for (int i = 2; i <= 9; i++) begin
      ev_at(4'(i), 3'b001);
      ev_at(4'(i), 3'b100);
    end
    ev_at(4'ha, 3'b001);
    ev_at(4'ha, 3'b000);
    ev_at(4'ha, 3'b101);
    ev_at(4'ha, 3'b100);
    chk("log size", 0, i_sink.got_q.size());
    chk("ind_state 10", 4'h1, ind_state[39:36]);
  endtask
  // first millisecond tick, counted from the first edge after reset release
  task automatic t_stamp();
    int n;
    n = 0;
    while (stamp == '0 && n < 51000) begin
      step(1);
      n++;
    end
    chk("stamp tick cycle", 6 + CLK_HZ / 1000, cyc);
    chk("stamp step", 1, stamp);
    i_sink.got_q.delete();
    close_in[0] = 1'b1;
    n = 0;
    while (evt_valid !== 1'b1 && n < 8) begin
      step(1);
      n++;
    end
    chk("event stamp", 1, evt_data.stamp);
    step(4);
    ev(3'b000);
    ev(3'b111);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 52000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    step(6);
    rst_b = 1;
    step(2);
    t_decode();
    t_events();
    t_select();
    t_burst();
    t_stamp();
    stop_test();
  end
endmodule

/* File: test/ism_properties.sv */
// checker: decode, event and time base relations at the top ports
// assumes selections stay steady while events drain
module ism_properties
  import ism_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire logic [NUM_IND-1:0]   open_status_in,
  input  wire logic [NUM_IND-1:0]   close_status_in,
  input  wire logic [NUM_IND*8-1:0] event_sel,
  input  wire logic [NUM_IND*4-1:0] ind_state,
  input  wire logic                 evt_valid,
  input  wire ism_event_t           evt_data,
  input  wire logic                 evt_lost,
  input  wire logic [STAMP_W-1:0]   stamp
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // decode after sync and register delay
  // ----------------------------------------
  sequence s_hold(o, c);
    (open_status_in[0] == o && close_status_in[0] == c) [*5];
  endsequence
  property p_inter; s_hold(0, 0) |=> ind_state[3:0] == 4'h4; endproperty
  a_inter: assert property (p_inter) else $error("state not intermediate");
  property p_bad; s_hold(1, 1) |=> ind_state[3:0] == 4'h8; endproperty
  a_bad: assert property (p_bad) else $error("state not bad");
  property p_open; s_hold(1, 0) |=> ind_state[3:0] == 4'h1; endproperty
  a_open: assert property (p_open) else $error("state not open");
  property p_closed; s_hold(0, 1) |=> ind_state[3:0] == 4'h2; endproperty
  a_closed: assert property (p_closed) else $error("state not closed");
  // ----------------------------------------
  // events and time base
  // ----------------------------------------
  property p_cause;
    $changed(ind_state[3:0]) && event_sel[7:0] == 8'hff |-> evt_valid && evt_data.instance_no == 4'h1;
  endproperty
  a_cause: assert property (p_cause) else $error("state change without event");
  property p_nosel; (event_sel == '0) [*3] |-> !evt_valid; endproperty
  a_nosel: assert property (p_nosel) else $error("unselected event stored");
  property p_inst; evt_valid |-> evt_data.instance_no inside {[4'h1:4'ha]}; endproperty
  a_inst: assert property (p_inst) else $error("instance number out of range");
  property p_stamp; stamp != $past(stamp) |-> stamp == $past(stamp) + 1; endproperty
  a_stamp: assert property (p_stamp) else $error("stamp jumped");
endmodule
bind ism_top ism_properties i_props (.clk_sys, .rst_b, .open_status_in, .close_status_in, .event_sel,
  .ind_state, .evt_valid, .evt_data, .evt_lost, .stamp);

/* File: test/ism_sink.sv */
// far-side model: the shared event buffer, logging every event
// assumes it sits beside ism_top on clk_sys
module ism_sink
  import ism_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       evt_valid,
  input  wire ism_event_t evt_data
);
  // instance, code, on flag; stamp left out to keep the log small
  logic [6:0] got_q [$];
  always @(posedge clk_sys) begin
    if (evt_valid) begin
      got_q.push_back({evt_data.instance_no, evt_data.event_code, evt_data.is_on});
    end
  end
endmodule
